//--- common/port_stats_pkg.sv
// Constants for the per-port frame statistics block
package port_stats_pkg;
    // Counter width and register layout
    localparam int unsigned CNT_W = 32;
    localparam int unsigned ADDR_W = 8;
    // Length thresholds in octets, check sequence included
    localparam logic [15:0] LEN_MIN = 16'h0040;    // 64
    localparam logic [15:0] LEN_127 = 16'h007F;
    localparam logic [15:0] LEN_255 = 16'h00FF;
    localparam logic [15:0] LEN_511 = 16'h01FF;
    localparam logic [15:0] LEN_1023 = 16'h03FF;
    localparam logic [15:0] LEN_STD = 16'h05EE;    // 1518
    localparam logic [15:0] LEN_TAG = 16'h05F2;    // 1522
    // Counter indices; byte address is index times four
    localparam int unsigned C_RX_OCT = 0;
    localparam int unsigned C_RX_LT64 = 1;
    localparam int unsigned C_RX_H64 = 2;   // 64 .. 1519-1522, seven bins
    localparam int unsigned C_RX_GT1522 = 9;
    localparam int unsigned C_RX_GOOD = 10;
    localparam int unsigned C_RX_UCAST = 11;
    localparam int unsigned C_RX_MCAST = 12;
    localparam int unsigned C_RX_BCAST = 13;
    localparam int unsigned C_RX_ERR = 14;
    localparam int unsigned C_JABBER = 15;
    localparam int unsigned C_FRAG = 16;
    localparam int unsigned C_ALIGN = 17;
    localparam int unsigned C_FCS = 18;
    localparam int unsigned C_OVERRUN = 19;
    localparam int unsigned C_DISC = 20;    // ten discard reasons, see DISC_*
    localparam int unsigned C_TX_OCT = 30;
    localparam int unsigned C_TX_H64 = 31;  // seven transmit bins
    localparam int unsigned N_CNT = 38;
    // Discard reason bit positions
    localparam int unsigned DISC_N = 10;
    localparam int unsigned DISC_LOCAL = 0;
    localparam int unsigned DISC_PAUSE = 1;
    localparam int unsigned DISC_FTYPE = 2;
    localparam int unsigned DISC_VMEMB = 3;
    localparam int unsigned DISC_VLAN = 4;
    localparam int unsigned DISC_MTREE = 5;
    localparam int unsigned DISC_RSVD = 6;
    localparam int unsigned DISC_STORM = 7;
    localparam int unsigned DISC_CFI = 8;
    localparam int unsigned DISC_CELL = 9;
    // Control register
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'hFC;
    localparam int unsigned CTRL_CLEAR = 0;
    localparam int unsigned CTRL_HALFDUP = 1;
    localparam int unsigned CTRL_STORM = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // Bus responses
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/port_frame_statistics.sv
// Per-port receive and transmit frame statistics counters with an AXI4-Lite slave
// Functional notes
// - Count all received octets, DA through FCS
// - Bin received frames under 64 octets
// - Bin frames of exactly 64 octets
// - Seven length bins, receive and transmit
// - Count well formed frames over 1522
// - Count good multicast, broadcast excluded
// - Count good broadcast apart from multicast
// - Jabber: over 1518 with bad FCS
// - Fragment count for frames under 64
// - Alignment: 64-1518, bad FCS, odd bits
// - FCS error: 64-1518, bad FCS, whole octets
// - Count frames dropped for port overload
// - Count PAUSE frames, frozen in half duplex
// - Count unacceptable frame type discards
// - Count VLAN ingress filtering discards
// - Count VLAN busy or unconfigured discards
// - Count multicast tree busy discards
// - Count reserved address discards
// - Count broadcast drops while storm guard on
// - Count CFI non-canonical RIF discards
// - Count cell descriptor shortage discards
// - Count same-port destination forwarding discards
`timescale 1ns/1ps
`default_nettype none
module port_frame_statistics (
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Receive frame status, one-cycle strobe
    input  wire logic                rx_done,
    input  wire logic [15:0]         rx_len,
    input  wire logic                rx_fcs_bad,
    input  wire logic                rx_dribble,
    input  wire logic                rx_mcast,
    input  wire logic                rx_bcast,
    input  wire logic                rx_pause,
    input  wire logic                rx_overrun,
    // Forwarding discard report, one-cycle strobe
    input  wire logic                fwd_drop,
    input  wire logic [9:0]          fwd_reason,
    // Transmit frame status, one-cycle strobe
    input  wire logic                tx_done,
    input  wire logic [15:0]         tx_len,
    // AXI4-Lite write address and data
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    localparam int unsigned W = port_stats_pkg::CNT_W;

    // Seven-bin histogram index, 64 up to 1522, else 7
    function automatic logic [2:0] bin_of(input logic [15:0] len);
        logic [2:0] b;
        b = 3'h7;
        if (len == port_stats_pkg::LEN_MIN) begin
            b = 3'h0;
        end else if (len > port_stats_pkg::LEN_MIN && len <= port_stats_pkg::LEN_127) begin
            b = 3'h1;
        end else if (len > port_stats_pkg::LEN_127 && len <= port_stats_pkg::LEN_255) begin
            b = 3'h2;
        end else if (len > port_stats_pkg::LEN_255 && len <= port_stats_pkg::LEN_511) begin
            b = 3'h3;
        end else if (len > port_stats_pkg::LEN_511 && len <= port_stats_pkg::LEN_1023) begin
            b = 3'h4;
        end else if (len > port_stats_pkg::LEN_1023 && len <= port_stats_pkg::LEN_STD) begin
            b = 3'h5;
        end else if (len > port_stats_pkg::LEN_STD && len <= port_stats_pkg::LEN_TAG) begin
            b = 3'h6;
        end
        return b;
    endfunction

    // Control and counters
    logic [2:0]   ctrl_q;
    logic         clear_q;
    logic [W-1:0] cnt_q [port_stats_pkg::N_CNT];
    logic [port_stats_pkg::N_CNT-1:0] inc;

    // Receive classification
    wire [2:0] rx_bin      = bin_of(rx_len);
    wire [2:0] tx_bin      = bin_of(tx_len);
    wire       rx_short    = rx_len < port_stats_pkg::LEN_MIN;
    wire       rx_norm     = !rx_short && rx_len <= port_stats_pkg::LEN_STD;
    wire       rx_over_std = rx_len > port_stats_pkg::LEN_STD;
    wire       rx_good     = rx_done && !rx_fcs_bad && !rx_dribble && !rx_short
                             && !rx_overrun;
    wire       rx_align    = rx_done && rx_norm && rx_fcs_bad && rx_dribble;
    wire       rx_fcs      = rx_done && rx_norm && rx_fcs_bad && !rx_dribble;
    wire       rx_jab      = rx_done && rx_over_std && rx_fcs_bad;
    wire       rx_frag     = rx_done && rx_short;
    wire       rx_long     = rx_done && rx_len > port_stats_pkg::LEN_TAG
                             && !rx_fcs_bad && !rx_dribble;
    wire       pause_ok    = rx_done && rx_pause && !rx_fcs_bad
                             && !ctrl_q[port_stats_pkg::CTRL_HALFDUP];
    wire       storm_ok    = fwd_drop && fwd_reason[port_stats_pkg::DISC_STORM]
                             && ctrl_q[port_stats_pkg::CTRL_STORM];

    always_comb begin
        inc = '0;
        inc[port_stats_pkg::C_RX_LT64] = rx_done && rx_short;
        for (int i = 0; i < 7; i++) begin
            inc[port_stats_pkg::C_RX_H64 + i] = rx_done && rx_bin == 3'(i);
            inc[port_stats_pkg::C_TX_H64 + i] = tx_done && tx_bin == 3'(i);
        end
        inc[port_stats_pkg::C_RX_GT1522] = rx_long;
        inc[port_stats_pkg::C_RX_GOOD] = rx_good;
        inc[port_stats_pkg::C_RX_UCAST] = rx_good && !rx_mcast && !rx_bcast;
        inc[port_stats_pkg::C_RX_MCAST] = rx_good && rx_mcast && !rx_bcast;
        inc[port_stats_pkg::C_RX_BCAST] = rx_good && rx_bcast;
        inc[port_stats_pkg::C_RX_ERR] = rx_jab || rx_frag || rx_align || rx_fcs;
        inc[port_stats_pkg::C_JABBER] = rx_jab;
        inc[port_stats_pkg::C_FRAG] = rx_frag;
        inc[port_stats_pkg::C_ALIGN] = rx_align;
        inc[port_stats_pkg::C_FCS] = rx_fcs;
        inc[port_stats_pkg::C_OVERRUN] = rx_done && rx_overrun;
        for (int r = 0; r < port_stats_pkg::DISC_N; r++) begin
            inc[port_stats_pkg::C_DISC + r] = fwd_drop && fwd_reason[r];
        end
        inc[port_stats_pkg::C_DISC + port_stats_pkg::DISC_PAUSE] = pause_ok;
        inc[port_stats_pkg::C_DISC + port_stats_pkg::DISC_STORM] = storm_ok;
    end

    // Octet totals widen a 16-bit length into the counter
    wire [W-1:0] rx_add = {{(W-16){1'b0}}, rx_len};
    wire [W-1:0] tx_add = {{(W-16){1'b0}}, tx_len};

    always_ff @(posedge aclk) begin
        for (int k = 0; k < port_stats_pkg::N_CNT; k++) begin
            if (!aresetn || clear_q) begin
                cnt_q[k] <= '0;
            end else if (k == port_stats_pkg::C_RX_OCT) begin
                if (rx_done) begin
                    cnt_q[k] <= cnt_q[k] + rx_add;
                end
            end else if (k == port_stats_pkg::C_TX_OCT) begin
                if (tx_done) begin
                    cnt_q[k] <= cnt_q[k] + tx_add;
                end
            end else if (inc[k]) begin
                cnt_q[k] <= cnt_q[k] + 1'b1;
            end
        end
    end

    // Write channel: address and data taken in either order
    logic       aw_have_q, w_have_q;
    logic       aw_free_q, w_free_q;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    wire        wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
    wire        wr_ctl = aw_q == port_stats_pkg::CTRL_ADDR;
    wire        wr_ok  = wr_ctl || (aw_q[7:2] < 6'(port_stats_pkg::N_CNT) && aw_q[1:0] == 2'h0);
    wire        wr_set = wr_go && wr_ctl && ws_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_free_q <= 1'b1;
            w_free_q <= 1'b1;
            aw_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= port_stats_pkg::RESP_OK;
            ctrl_q <= port_stats_pkg::CTRL_RST;
            clear_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_free_q <= 1'b0;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_free_q <= 1'b0;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                aw_free_q <= 1'b1;
                w_free_q <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? port_stats_pkg::RESP_OK : port_stats_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Clear bit self-clears after one cycle
            clear_q <= wr_set && wd_q[port_stats_pkg::CTRL_CLEAR];
            if (wr_set) begin
                ctrl_q <= {wd_q[2:1], 1'b0};
            end
        end
    end

    assign s_axi_awready = aw_free_q;
    assign s_axi_wready  = w_free_q;

    // Read channel: one-cycle answer
    wire        rd_ctl = s_axi_araddr == port_stats_pkg::CTRL_ADDR;
    wire [5:0]  rd_idx = s_axi_araddr[7:2];
    wire        rd_hit = rd_idx < 6'(port_stats_pkg::N_CNT) && s_axi_araddr[1:0] == 2'h0;
    wire [31:0] rd_val = rd_ctl ? {29'h0, ctrl_q} : (rd_hit ? cnt_q[rd_idx] : 32'h0000_0000);
    logic       rv_q;
    logic       ar_free_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rv_q <= 1'b0;
            ar_free_q <= 1'b1;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= port_stats_pkg::RESP_OK;
        end else if (s_axi_arvalid && !rv_q) begin
            rv_q <= 1'b1;
            ar_free_q <= 1'b0;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= (rd_ctl || rd_hit) ? port_stats_pkg::RESP_OK
                                              : port_stats_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rv_q <= 1'b0;
            ar_free_q <= 1'b1;
        end
    end

    assign s_axi_rvalid  = rv_q;
    assign s_axi_arready = ar_free_q;

    // Checks
    property p_frag_count;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && rx_short && !clear_q) |=> cnt_q[port_stats_pkg::C_FRAG]
            == $past(cnt_q[port_stats_pkg::C_FRAG]) + 1;
    endproperty
    a_frag_count: assert property (p_frag_count) else $error("fragment not counted");

    property p_jab;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && rx_fcs_bad && rx_len == 16'h05EF && !clear_q)
            |=> cnt_q[port_stats_pkg::C_JABBER] != $past(cnt_q[port_stats_pkg::C_JABBER]);
    endproperty
    a_jab: assert property (p_jab) else $error("jabber missed");

    property p_fcs1518;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && rx_fcs_bad && !rx_dribble && rx_len == 16'h05EE && !clear_q)
            |=> cnt_q[port_stats_pkg::C_FCS] != $past(cnt_q[port_stats_pkg::C_FCS]);
    endproperty
    a_fcs1518: assert property (p_fcs1518) else $error("fcs error missed");

    property p_align;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && rx_fcs_bad && rx_dribble && rx_len == 16'h0040 && !clear_q)
            |=> cnt_q[port_stats_pkg::C_ALIGN] != $past(cnt_q[port_stats_pkg::C_ALIGN]);
    endproperty
    a_align: assert property (p_align) else $error("alignment missed");

    property p_pause_half;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_q[port_stats_pkg::CTRL_HALFDUP] && !clear_q |=>
            $stable(cnt_q[port_stats_pkg::C_DISC + port_stats_pkg::DISC_PAUSE]);
    endproperty
    a_pause_half: assert property (p_pause_half) else $error("pause counted in half duplex");

    property p_bcast_not_mc;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && rx_bcast && !clear_q) |=>
            $stable(cnt_q[port_stats_pkg::C_RX_MCAST]);
    endproperty
    a_bcast_not_mc: assert property (p_bcast_not_mc) else $error("broadcast in multicast");

    property p_long_bad;
        @(posedge aclk) disable iff (!aresetn)
        (rx_fcs_bad || !rx_done) && !clear_q |=>
            $stable(cnt_q[port_stats_pkg::C_RX_GT1522]);
    endproperty
    a_long_bad: assert property (p_long_bad) else $error("bad long frame counted");

    sequence s_clear_req;
        wr_set && wd_q[port_stats_pkg::CTRL_CLEAR];
    endsequence
    property p_clear;
        @(posedge aclk) disable iff (!aresetn)
        s_clear_req |=> ##1 cnt_q[port_stats_pkg::C_FRAG] == '0
            && cnt_q[port_stats_pkg::C_RX_OCT] == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_bcast_count;
        @(posedge aclk) disable iff (!aresetn)
        (rx_good && rx_bcast && !clear_q) |=> cnt_q[port_stats_pkg::C_RX_BCAST]
            == $past(cnt_q[port_stats_pkg::C_RX_BCAST]) + 1;
    endproperty
    a_bcast_count: assert property (p_bcast_count) else $error("broadcast missed");

    property p_mcast_count;
        @(posedge aclk) disable iff (!aresetn)
        (rx_good && rx_mcast && !rx_bcast && !clear_q) |=> cnt_q[port_stats_pkg::C_RX_MCAST]
            == $past(cnt_q[port_stats_pkg::C_RX_MCAST]) + 1;
    endproperty
    a_mcast_count: assert property (p_mcast_count) else $error("multicast missed");

    property p_lt64;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && rx_short && !clear_q) |=> cnt_q[port_stats_pkg::C_RX_LT64]
            == $past(cnt_q[port_stats_pkg::C_RX_LT64]) + 1;
    endproperty
    a_lt64: assert property (p_lt64) else $error("short bin missed");

    property p_bin64;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && rx_len == port_stats_pkg::LEN_MIN && !clear_q)
            |=> cnt_q[port_stats_pkg::C_RX_H64] == $past(cnt_q[port_stats_pkg::C_RX_H64]) + 1;
    endproperty
    a_bin64: assert property (p_bin64) else $error("64 octet bin missed");

    property p_long_ok;
        @(posedge aclk) disable iff (!aresetn)
        (rx_long && !clear_q) |=> cnt_q[port_stats_pkg::C_RX_GT1522]
            == $past(cnt_q[port_stats_pkg::C_RX_GT1522]) + 1;
    endproperty
    a_long_ok: assert property (p_long_ok) else $error("long frame missed");

    property p_overrun;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && rx_overrun && !clear_q) |=> cnt_q[port_stats_pkg::C_OVERRUN]
            == $past(cnt_q[port_stats_pkg::C_OVERRUN]) + 1;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");

    property p_storm_off;
        @(posedge aclk) disable iff (!aresetn)
        !ctrl_q[port_stats_pkg::CTRL_STORM] && !clear_q |=>
            $stable(cnt_q[port_stats_pkg::C_DISC + port_stats_pkg::DISC_STORM]);
    endproperty
    a_storm_off: assert property (p_storm_off) else $error("storm drop counted while off");

    property p_octets;
        @(posedge aclk) disable iff (!aresetn)
        (rx_done && !clear_q) |=> cnt_q[port_stats_pkg::C_RX_OCT]
            == $past(cnt_q[port_stats_pkg::C_RX_OCT]) + $past(rx_add);
    endproperty
    a_octets: assert property (p_octets) else $error("octets not added");

    property p_bvalid_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

    property p_rvalid_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
endmodule
`default_nettype wire

//--- tb/frame_source_model.sv
// Model of the port's MAC frame paths and forwarding logic driving status strobes
`timescale 1ns/1ps
`default_nettype none
module frame_source_model (
    // Clock
    input  wire logic        aclk,
    // Receive status: overrun, fcs, dribble, mcast, bcast, pause
    output logic             rx_done,
    output logic [15:0]      rx_len,
    output logic [5:0]       rx_flags,
    // Forwarding discards
    output logic             fwd_drop,
    output logic [9:0]       fwd_reason,
    // Transmit status
    output logic             tx_done,
    output logic [15:0]      tx_len
);
    initial begin
        rx_done = 1'b0;
        rx_len = 16'h0000;
        rx_flags = 6'h00;
        fwd_drop = 1'b0;
        fwd_reason = 10'h000;
        tx_done = 1'b0;
        tx_len = 16'h0000;
    end
    task automatic send_rx(input logic [15:0] len, input logic [5:0] fl);
        @(posedge aclk);
        rx_done <= 1'b1;
        rx_len <= len;
        rx_flags <= fl;
    endtask
    task automatic send_tx(input logic [15:0] len);
        @(posedge aclk);
        tx_done <= 1'b1;
        tx_len <= len;
    endtask
    task automatic send_drop(input logic [9:0] r);
        @(posedge aclk);
        fwd_drop <= 1'b1;
        fwd_reason <= r;
    endtask
    // Strobes drop; qualifiers stop showing the last frame
    task automatic idle();
        @(posedge aclk);
        rx_done <= 1'b0;
        rx_len <= ~rx_len;
        rx_flags <= ~rx_flags;
        fwd_drop <= 1'b0;
        fwd_reason <= ~fwd_reason;
        tx_done <= 1'b0;
        tx_len <= ~tx_len;
    endtask
endmodule
`default_nettype wire

//--- tb/port_frame_statistics_test.sv
// Self-checking bench for the per-port frame statistics counters
`timescale 1ns/1ps
`default_nettype none
module port_frame_statistics_test;
    typedef struct { logic [15:0] len; logic [5:0] fl; int bin; } row_s;
    logic aclk, aresetn, rx_done, fwd_drop, tx_done;
    logic [15:0] rx_len, tx_len;
    logic [5:0] rx_fl;
    logic [9:0] fwd_reason;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    logic [31:0] exp_q [port_stats_pkg::N_CNT];
    int err_total, num_checks, cyc;
    row_s rows [20] = '{'{16'h003F,6'h00,1}, '{16'h0028,6'h10,1}, '{16'h0040,6'h00,2},
        '{16'h0041,6'h04,3}, '{16'h007F,6'h00,3}, '{16'h0080,6'h02,4}, '{16'h00FF,6'h06,4},
        '{16'h0100,6'h00,5}, '{16'h01FF,6'h00,5}, '{16'h0200,6'h04,6}, '{16'h03FF,6'h00,6},
        '{16'h0400,6'h00,7}, '{16'h05EE,6'h10,7}, '{16'h03E8,6'h18,6}, '{16'h0040,6'h18,2},
        '{16'h05EF,6'h00,8}, '{16'h05F2,6'h10,8}, '{16'h05F3,6'h00,9}, '{16'h07D0,6'h18,-1},
        '{16'h0040,6'h05,2}};
    frame_source_model src_u (.aclk(aclk), .rx_done(rx_done), .rx_len(rx_len),
        .rx_flags(rx_fl), .fwd_drop(fwd_drop), .fwd_reason(fwd_reason), .tx_done(tx_done),
        .tx_len(tx_len));
    port_frame_statistics dut_u (.aclk(aclk), .aresetn(aresetn), .rx_done(rx_done),
        .rx_len(rx_len), .rx_fcs_bad(rx_fl[4]), .rx_dribble(rx_fl[3]), .rx_mcast(rx_fl[2]),
        .rx_bcast(rx_fl[1]), .rx_pause(rx_fl[0]), .rx_overrun(rx_fl[5]), .fwd_drop(fwd_drop),
        .fwd_reason(fwd_reason), .tx_done(tx_done), .tx_len(tx_len), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input int i, input logic [31:0] want);
        axi_rd(8'(i * 4), v, r);
        chk($sformatf("counter %0d", i), v, want);
    endtask
    task automatic rx_frame(input row_s w);
        logic e;
        e = w.fl[4];
        src_u.send_rx(w.len, w.fl);
        exp_q[0] += 32'(w.len);
        if (w.bin >= 0) exp_q[w.bin]++;
        if (e || w.len < port_stats_pkg::LEN_MIN) exp_q[14]++;
        if (!e && !w.fl[3] && !w.fl[5] && w.len >= port_stats_pkg::LEN_MIN) begin
            exp_q[10]++;
            exp_q[w.fl[1] ? 13 : (w.fl[2] ? 12 : 11)]++;
        end
        if (w.len < port_stats_pkg::LEN_MIN) exp_q[16]++;
        if (e && w.len > port_stats_pkg::LEN_STD) exp_q[15]++;
        if (e && w.len >= port_stats_pkg::LEN_MIN && w.len <= port_stats_pkg::LEN_STD)
            exp_q[w.fl[3] ? 17 : 18]++;
        if (w.fl[0] && !w.fl[4]) exp_q[21]++;
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0000_0000, 4'hF};
        {err_total, num_checks, cyc} = {32'h0, 32'h0, 32'h0};
        foreach (exp_q[i]) exp_q[i] = 32'h0000_0000;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(0, 32'h0000_0000);
        axi_wr(port_stats_pkg::CTRL_ADDR, 32'h0000_0004, r);
        chk("bresp", {30'h0, r}, {30'h0, port_stats_pkg::RESP_OK});
        foreach (rows[i]) rx_frame(rows[i]);
        src_u.idle();
        foreach (rows[i]) if (rows[i].bin >= 2 && rows[i].bin <= 8) begin
            src_u.send_tx(rows[i].len);
            exp_q[30] += 32'(rows[i].len);
            exp_q[rows[i].bin + 29]++;
        end
        src_u.idle();
        for (int b = 0; b <= 10; b++) begin
            src_u.send_drop(b == 10 ? 10'h3FD : 10'(1 << b));
            for (int k = 0; k < 10; k++) if (k != 1 && (b == 10 ? k != 1 : k == b)) exp_q[20 + k]++;
        end
        src_u.idle();
        axi_wr(8'h00, 32'h1234_5678, r);
        chk("counter write bresp", {30'h0, r}, {30'h0, port_stats_pkg::RESP_OK});
        for (int i = 0; i < 38; i++) rd_chk(i, exp_q[i]);
        src_u.send_rx(16'h0040, 6'h20);
        src_u.idle();
        rd_chk(19, 32'h0000_0001);
        axi_wr(port_stats_pkg::CTRL_ADDR, 32'h0000_0006, r);
        src_u.send_rx(16'h0040, 6'h05);
        src_u.idle();
        rd_chk(21, exp_q[21]);
        axi_rd(8'hA0, v, r);
        chk("unmapped rresp", {30'h0, r}, {30'h0, port_stats_pkg::RESP_SLVERR});
        chk("unmapped rdata", v, 32'h0000_0000);
        axi_rd(8'h02, v, r);
        chk("misaligned rresp", {30'h0, r}, {30'h0, port_stats_pkg::RESP_SLVERR});
        axi_wr(port_stats_pkg::CTRL_ADDR, 32'h0000_0001, r);
        axi_rd(port_stats_pkg::CTRL_ADDR, v, r);
        chk("ctrl after clear", v, 32'h0000_0000);
        for (int i = 0; i < 38; i++) rd_chk(i, 32'h0000_0000);
        src_u.send_drop(10'h080);
        src_u.idle();
        rd_chk(27, 32'h0000_0000);
        axi_wr(8'hA0, 32'h0000_0000, r);
        chk("unmapped bresp", {30'h0, r}, {30'h0, port_stats_pkg::RESP_SLVERR});
        src_u.send_rx(16'h0040, 6'h00);
        src_u.idle();
        axi_wr(port_stats_pkg::CTRL_ADDR, 32'h0000_0006, r);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(port_stats_pkg::CTRL_ADDR, v, r);
        chk("ctrl after reset", v, 32'h0000_0000);
        rd_chk(0, 32'h0000_0000);
        give_verdict();
    end
endmodule
`default_nettype wire
